//--- swm_pkg.sv
package swm_pkg;

  // Register byte offsets within the clock and reset module window
  localparam logic [7:0] SWM_OFF_STATUS = 8'h18;
  localparam logic [7:0] SWM_OFF_MODREP = 8'h1C;
  localparam logic [7:0] SWM_OFF_COUNT = 8'h20;
  localparam logic [7:0] SWM_OFF_TIMEOUT = 8'h24;
  localparam logic [7:0] SWM_OFF_CTRL = 8'h40;
  localparam logic [7:0] SWM_OFF_MASK = 8'h44;

  // Status and mask field positions
  localparam int SWM_ST_SYNC = 0;
  localparam int SWM_ST_HIB = 1;

  // Control field positions
  localparam int SWM_CTRL_TWE = 0;
  localparam int SWM_CTRL_HIB = 1;
  localparam int SWM_CTRL_GO = 2;

  // Module enable report field positions
  localparam int SWM_MB_AIM = 17;
  localparam int SWM_MB_TRACE = 15;
  localparam int SWM_MB_DEBUG = 14;
  localparam int SWM_MB_ADC = 12;
  localparam int SWM_MB_SFLASH = 11;
  localparam int SWM_MB_AUDIO = 10;
  localparam int SWM_MB_TWI = 9;
  localparam int SWM_MB_RADIO = 8;
  localparam int SWM_MB_TIMER = 7;
  localparam int SWM_MB_UART_B = 6;
  localparam int SWM_MB_UART_A = 5;
  localparam int SWM_MB_GPIO = 4;
  localparam int SWM_MB_SPI = 3;
  localparam int SWM_MB_SEC = 2;
  localparam int SWM_MB_MAC = 1;
  localparam int SWM_MB_CPU = 0;

  // Reset values and bus response codes
  localparam logic [31:0] SWM_MODREP_RESET = 32'h0000_4001;
  localparam logic [31:0] SWM_TIMEOUT_RESET = 32'h0000_0000;
  localparam logic [1:0] SWM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SWM_RESP_SLVERR = 2'h2;

  // Sleep timer tick: bus clock divided by 128
  localparam logic [7:0] SWM_TICK_LAST = 8'h7F;

  typedef enum logic [4:0] {
    SWM_RUN = 5'h01,
    SWM_ENTER = 5'h02,
    SWM_ARMED = 5'h04,
    SWM_ASLEEP = 5'h08,
    SWM_WAKE = 5'h10
  } swm_fsm_t;

  typedef struct packed {
    logic analog_iface_enabled;
    logic trace_module_enabled;
    logic debug_port_enabled;
    logic converter_enabled;
    logic serial_flash_enabled;
    logic audio_serial_enabled;
    logic two_wire_enabled;
    logic radio_iface_enabled;
    logic [3:0] timer_counter_clk_en;
    logic serial_port_b_enabled;
    logic serial_port_a_enabled;
    logic gpio_enabled;
    logic serial_periph_enabled;
    logic security_unit_enabled;
    logic mac_accel_enabled;
    logic cpu_enabled;
  } swm_mod_en_t;

  typedef struct packed {
    logic rtc;
    logic [3:0] ext;
  } swm_wake_src_t;

  typedef struct packed {
    swm_fsm_t fsm;
    logic [1:0] status;
    logic [1:0] mask;
    logic timer_wake_enable;
    logic hib_mode;
    logic [31:0] timeout;
    logic [31:0] count;
    logic [7:0] div;
    logic [31:0] modrep;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic clk_stop;
    logic mac_freeze;
  } swm_state_t;

  localparam swm_state_t SWM_STATE_RESET = '{
    fsm: SWM_RUN, status: 2'h0, mask: 2'h0, timer_wake_enable: 1'b0, hib_mode: 1'b0,
    timeout: SWM_TIMEOUT_RESET, count: 32'h0000_0000, div: 8'h00, modrep: SWM_MODREP_RESET,
    aw_got: 1'b0, awaddr: 8'h00, w_got: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0,
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: 2'h0, arready: 1'b1, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: 2'h0, irq: 1'b0, clk_stop: 1'b0, mac_freeze: 1'b0
  };

endpackage

//--- swm_sleep_wake_status.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps

module swm_sleep_wake_status
  import swm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire swm_mod_en_t mod_en,
  input wire swm_wake_src_t wake_src,
  output logic irq,
  output logic cpu_clk_stop,
  output logic mac_timer_freeze,
  output logic [31:0] wake_timer_count
);

  swm_state_t s_r;
  swm_state_t s_nxt;

  function automatic logic [7:0] swm_word(input logic [7:0] a);
    return {a[7:2], 2'h0};
  endfunction

  function automatic logic [31:0] swm_pack_mod(input swm_mod_en_t m);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[SWM_MB_AIM] = m.analog_iface_enabled;
    v[SWM_MB_TRACE] = m.trace_module_enabled;
    v[SWM_MB_DEBUG] = m.debug_port_enabled;
    v[SWM_MB_ADC] = m.converter_enabled;
    v[SWM_MB_SFLASH] = m.serial_flash_enabled;
    v[SWM_MB_AUDIO] = m.audio_serial_enabled;
    v[SWM_MB_TWI] = m.two_wire_enabled;
    v[SWM_MB_RADIO] = m.radio_iface_enabled;
    v[SWM_MB_TIMER] = |m.timer_counter_clk_en;
    v[SWM_MB_UART_B] = m.serial_port_b_enabled;
    v[SWM_MB_UART_A] = m.serial_port_a_enabled;
    v[SWM_MB_GPIO] = m.gpio_enabled;
    v[SWM_MB_SPI] = m.serial_periph_enabled;
    v[SWM_MB_SEC] = m.security_unit_enabled;
    v[SWM_MB_MAC] = m.mac_accel_enabled;
    v[SWM_MB_CPU] = m.cpu_enabled;
    return v;
  endfunction

  function automatic logic [31:0] swm_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // Address map decode, shared by the write and read paths
  function automatic logic swm_known(input logic [7:0] a);
    logic k;
    k = 1'b0;
    case (a)
      SWM_OFF_STATUS, SWM_OFF_MODREP, SWM_OFF_COUNT: begin
        k = 1'b1;
      end
      SWM_OFF_TIMEOUT, SWM_OFF_CTRL, SWM_OFF_MASK: begin
        k = 1'b1;
      end
      default: begin
        k = 1'b0;
      end
    endcase
    return k;
  endfunction

  // Read mux takes the state by value, so a read can never disturb a flag
  function automatic logic [31:0] swm_read_word(input swm_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      SWM_OFF_STATUS: begin
        v[SWM_ST_SYNC] = s.status[SWM_ST_SYNC];
        v[SWM_ST_HIB] = s.status[SWM_ST_HIB];
      end
      SWM_OFF_MODREP: begin
        v = s.modrep;
      end
      SWM_OFF_COUNT: begin
        v = s.count;
      end
      SWM_OFF_TIMEOUT: begin
        v = s.timeout;
      end
      SWM_OFF_CTRL: begin
        // Start bit is a strobe and always reads back as zero
        v[SWM_CTRL_TWE] = s.timer_wake_enable;
        v[SWM_CTRL_HIB] = s.hib_mode;
      end
      SWM_OFF_MASK: begin
        v[SWM_ST_SYNC] = s.mask[SWM_ST_SYNC];
        v[SWM_ST_HIB] = s.mask[SWM_ST_HIB];
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  // Sleep timer advance; wraps silently at the top of its range
  function automatic logic [31:0] swm_count_step(input logic [31:0] c, input logic t);
    return t ? c + 32'h0000_0001 : c;
  endfunction

  // Any pad or the real-time clock ends sleep; the timer only when enabled
  function automatic logic swm_wake_due(input swm_state_t s, input swm_wake_src_t w);
    logic due;
    due = w.rtc || (|w.ext);
    if (s.timer_wake_enable && (s.count >= s.timeout)) begin
      due = 1'b1;
    end
    return due;
  endfunction

  // Set wins over a clear landing in the same cycle
  function automatic logic [1:0] swm_flags(input logic [1:0] cur, input logic [1:0] c,
                                           input logic [1:0] s);
    return (cur & ~c) | s;
  endfunction

  logic tick;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [1:0] clr;
  logic [1:0] set;
  logic sleep_go;
  logic wake_due;
  logic [31:0] ctrl_new;

  always_comb begin
    s_nxt = s_r;
    set = 2'h0;
    clr = 2'h0;
    sleep_go = 1'b0;
    ctrl_new = 32'h0000_0000;
    tick = (s_r.div == SWM_TICK_LAST);
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    wr_addr = swm_word(s_r.awaddr);
    rd_addr = swm_word(s_axi_araddr);

    // Write address and data may arrive in either order
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
      s_nxt.awready = 1'b0;
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
      s_nxt.wready = 1'b0;
    end

    wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = swm_known(wr_addr) ? SWM_RESP_OKAY : SWM_RESP_SLVERR;
      case (wr_addr)
        SWM_OFF_STATUS: begin
          if (s_r.wstrb[0]) begin
            clr = s_r.wdata[1:0];
          end
        end
        SWM_OFF_MASK: begin
          if (s_r.wstrb[0]) begin
            s_nxt.mask = s_r.wdata[1:0];
          end
        end
        SWM_OFF_TIMEOUT: begin
          s_nxt.timeout = swm_merge(s_r.timeout, s_r.wdata, s_r.wstrb);
        end
        SWM_OFF_CTRL: begin
          if (s_r.wstrb[0]) begin
            ctrl_new = s_r.wdata;
            s_nxt.timer_wake_enable = ctrl_new[SWM_CTRL_TWE];
            s_nxt.hib_mode = ctrl_new[SWM_CTRL_HIB];
            sleep_go = ctrl_new[SWM_CTRL_GO];
          end
        end
        SWM_OFF_MODREP, SWM_OFF_COUNT: begin
          // Read-only; write accepted and dropped
        end
        default: begin
          // Unmapped offset: no effect, error answer chosen above
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    // Reads have no side effects on any flag
    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = swm_read_word(s_r, rd_addr);
      s_nxt.rresp = swm_known(rd_addr) ? SWM_RESP_OKAY : SWM_RESP_SLVERR;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    wake_due = swm_wake_due(s_r, wake_src);

    case (s_r.fsm)
      SWM_RUN: begin
        if (sleep_go) begin
          s_nxt.fsm = SWM_ENTER;
          s_nxt.count = 32'h0000_0000;
          s_nxt.div = 8'h00;
          s_nxt.mac_freeze = 1'b1;
        end
      end
      SWM_ENTER: begin
        // Timer held at zero until its first tick
        if (tick) begin
          set[SWM_ST_SYNC] = 1'b1;
          s_nxt.fsm = SWM_ARMED;
        end
      end
      SWM_ARMED: begin
        s_nxt.count = swm_count_step(s_r.count, tick);
        // Software must have saved the frozen timer by now
        if (clr[SWM_ST_SYNC] && s_r.status[SWM_ST_SYNC]) begin
          s_nxt.fsm = SWM_ASLEEP;
          s_nxt.clk_stop = 1'b1;
        end
      end
      SWM_ASLEEP: begin
        s_nxt.count = swm_count_step(s_r.count, tick);
        if (wake_due) begin
          s_nxt.fsm = SWM_WAKE;
        end
      end
      SWM_WAKE: begin
        // Wait for a tick edge so the count is stable when flagged
        if (tick) begin
          set[SWM_ST_SYNC] = 1'b1;
          set[SWM_ST_HIB] = s_r.hib_mode && s_r.timer_wake_enable;
          s_nxt.clk_stop = 1'b0;
          s_nxt.mac_freeze = 1'b0;
          s_nxt.fsm = SWM_RUN;
        end
      end
      default: begin
        s_nxt.fsm = SWM_RUN;
        s_nxt.clk_stop = 1'b0;
        s_nxt.mac_freeze = 1'b0;
      end
    endcase

    s_nxt.status = swm_flags(s_r.status, clr, set);
    s_nxt.modrep = swm_pack_mod(mod_en);
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= SWM_STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign irq = s_r.irq;
  assign cpu_clk_stop = s_r.clk_stop;
  assign mac_timer_freeze = s_r.mac_freeze;
  assign wake_timer_count = s_r.count;

endmodule // swm_sleep_wake_status

//--- swm_sleep_wake_status_props.sv
`timescale 1ns/1ps
module swm_sleep_wake_status_props
  import swm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire swm_mod_en_t mod_en,
  input wire logic cpu_clk_stop,
  input wire logic mac_timer_freeze,
  input wire logic [31:0] wake_timer_count
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic logic [31:0] rep(swm_mod_en_t m);
    return {14'h0, m.analog_iface_enabled, 1'h0, m.trace_module_enabled, m.debug_port_enabled,
      1'h0, m.converter_enabled, m.serial_flash_enabled, m.audio_serial_enabled,
      m.two_wire_enabled, m.radio_iface_enabled, |m.timer_counter_clk_en, m[6:0]};
  endfunction

  a_stop_needs_freeze: assert property (cpu_clk_stop |-> mac_timer_freeze)
    else $error("clock stop without timer freeze");
  a_entry_count_zero: assert property (
    $rose(mac_timer_freeze) |-> (wake_timer_count == 32'h0)[*8])
    else $error("sleep count not zero at entry");
  a_count_step_one: assert property (
    mac_timer_freeze && $past(mac_timer_freeze) && $changed(wake_timer_count)
    |-> wake_timer_count == $past(wake_timer_count) + 32'h1)
    else $error("sleep count skipped");
  a_count_held_awake: assert property (
    !mac_timer_freeze ##1 !mac_timer_freeze |-> $stable(wake_timer_count))
    else $error("count moved while awake");
  a_wake_release: assert property ($fell(cpu_clk_stop) |-> !mac_timer_freeze)
    else $error("freeze still set at wake");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_report_map: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h07 && $past(aresetn)
    && $stable(mod_en) |=> s_axi_rdata == rep($past(mod_en)))
    else $error("module report wrong");
endmodule // swm_sleep_wake_status_props

//--- swm_sleep_wake_status_tb.sv
`timescale 1ns/1ps
module swm_sleep_wake_status_tb
  import swm_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, wake_timer_count;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic irq, cpu_clk_stop, mac_timer_freeze;
  swm_mod_en_t mod_en = 19'h10001;
  swm_wake_src_t wake_src = 5'h0;
  int n_mismatch = 0, samples_checked = 0;
  logic [18:0] row_in [13] = '{19'h0, 19'h40000, 19'h20000, 19'h10000, 19'h8000, 19'h4000,
    19'h2000, 19'h1000, 19'h800, 19'h80, 19'h400, 19'h7F, 19'h7FFFF};
  logic [31:0] row_exp [13] = '{32'h0, 32'h20000, 32'h8000, 32'h4000, 32'h1000, 32'h800,
    32'h400, 32'h200, 32'h100, 32'h80, 32'h80, 32'h7F, 32'h2DFFF};

  swm_sleep_wake_status dut (.*);

  always #20 aclk = ~aclk;

  task automatic finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Ready is sampled before the edge's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Skip two edges so a level left from the last request is not taken
  task automatic waitirq;
    repeat (2) @(posedge aclk);
    repeat (700) if (!irq) @(posedge aclk);
    chk(32'(irq), 32'h1);
  endtask

  task automatic nap(input logic [31:0] c);
    wr(8'h40, c, 2'h0);
    chk(32'(mac_timer_freeze), 32'h1);
    chk(wake_timer_count, 32'h0);
    waitirq;
    rd(8'h18, 32'h1);
    rd(8'h18, 32'h1);
    chk(wake_timer_count, 32'h0);
    wr(8'h18, 32'h1, 2'h0);
    @(posedge aclk);
    chk(32'(cpu_clk_stop), 32'h1);
  endtask

  task automatic wake(input swm_wake_src_t s, input logic [31:0] st, input logic ib);
    wake_src <= s;
    waitirq;
    wake_src <= 5'h0;
    chk(32'(cpu_clk_stop), 32'h0);
    chk(32'(mac_timer_freeze), 32'h0);
    rd(8'h18, st);
    wr(8'h18, 32'h2, 2'h0);
    rd(8'h18, 32'h1);
    @(posedge aclk);
    chk(32'(irq), 32'(ib));
    wr(8'h18, 32'h1, 2'h0);
    rd(8'h18, 32'h0);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h1C, 32'h4001);
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 13; i++) begin
      mod_en <= row_in[i];
      @(posedge aclk);
      rd(8'h1C, row_exp[i]);
    end
    wr(8'h1C, 32'h0, 2'h0);
    rd(8'h1C, 32'h2DFFF);
    wr(8'h30, 32'h1, 2'h2);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h44, 32'h3, 2'h0);
    rd(8'h44, 32'h3);
    nap(32'h4);
    wake(5'h10, 32'h1, 1'h1);
    // Hibernate mode alone must not raise the hibernate flag
    nap(32'h6);
    wake(5'h01, 32'h1, 1'h1);
    wr(8'h24, 32'h2, 2'h0);
    rd(8'h24, 32'h2);
    nap(32'h7);
    wr(8'h44, 32'h2, 2'h0);
    wake(5'h0, 32'h3, 1'h0);
    // Timer woke at a timeout of two ticks; the count keeps that span
    rd(8'h20, 32'h2);
    chk(wake_timer_count, 32'h2);
    // Reset in the middle of a sleep entry must drop every sleep output
    wr(8'h40, 32'h4, 2'h0);
    chk(32'(mac_timer_freeze), 32'h1);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(32'(mac_timer_freeze), 32'h0);
    chk(32'(cpu_clk_stop), 32'h0);
    chk(32'(irq), 32'h0);
    chk(wake_timer_count, 32'h0);
    rd(8'h18, 32'h0);
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    finish_test;
  end
endmodule // swm_sleep_wake_status_tb

bind swm_sleep_wake_status swm_sleep_wake_status_props u_props (.*);
